/* File: src/sdram_map.svh */
// Purpose: field positions, reset values and sizes of the sdram core
// Assumes: included by bare name wherever a constant is needed
// Notes:   definitions only
`ifndef SDRAM_MAP_SVH
`define SDRAM_MAP_SVH

// data and address sizing
`define DQ_W            16
`define COL_W           8
`define ADDR_W          12
`define STORE_WORDS     512
`define WBUF_DEPTH      32

// address pin roles
`define BANK_BIT        11
`define AP_BIT          10

// mode register fields, taken from the address pins
`define MR_BL_LSB       0
`define MR_BL_MSB       2
`define MR_BT_BIT       3
`define MR_CL_LSB       4
`define MR_CL_MSB       6
`define MR_WB_BIT       9
`define MR_CL3_CODE     3'h3
`define BL_FULL_CODE    3'h7

// reset values of mode fields
`define RST_BL_CODE     3'h0
`define RST_INTERLEAVE  1'h0
`define RST_CL3         1'h0
`define RST_SINGLE_WR   1'h0

`endif

/* File: src/sdram_pkg.sv */
// Purpose: types shared by the sdram core and its write buffer
// Assumes: sdram_map.svh supplies the sizes
// Notes:   no logic here
`include "sdram_map.svh"

package sdram_pkg;

  typedef enum logic [2:0]
  {
    CMD_NOP,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_PRE,
    CMD_BST,
    CMD_REF,
    CMD_MRS
  } cmd_t;

  typedef struct packed
  {
    logic                 bank;
    logic [`COL_W-1:0]    col;
    logic [1:0]           lane_we;
    logic [`DQ_W-1:0]     data;
  } wentry_t;

  typedef struct packed
  {
    logic                      cke_q;
    logic [1:0]                bank_act;
    logic [2:0]                bl_code;
    logic                      interleave;
    logic                      cl3;
    logic                      single_wr;
    logic                      b_act;
    logic                      b_wr;
    logic                      b_bank;
    logic                      b_ap;
    logic [`COL_W-1:0]         b_start;
    logic [`COL_W-1:0]         b_cnt;
    logic [1:0]                pv;
    logic [1:0][`DQ_W-1:0]     pd;
    logic [1:0]                mask_q;
    logic [`DQ_W-1:0]          dq;
    logic [1:0]                oe_n;
  } state_t;

endpackage

/* File: src/wbuf_if.sv */
// Purpose: carries write entries from the core into its buffer and out
// Assumes: one clock domain
// Notes:   valid/ready on both sides
`timescale 1ns/1ps

interface wbuf_if;
  import sdram_pkg::*;
  logic    push_valid;
  logic    push_ready;
  wentry_t push_data;
  logic    pop_valid;
  logic    pop_ready;
  wentry_t pop_data;

  modport core_side (output push_valid, input push_ready,
                     output push_data, input pop_valid,
                     output pop_ready, input pop_data);
  modport fifo_side (input push_valid, output push_ready,
                     input push_data, output pop_valid,
                     input pop_ready, output pop_data);
endinterface

/* File: src/sdram_wbuf.sv */
// Purpose: write data buffer between pin capture and the storage array
// Assumes: synchronous active-low reset, one clock
// Notes:   full and empty are exact; ready drops when full
`timescale 1ns/1ps

`include "sdram_map.svh"

module sdram_wbuf
#(
  parameter int WIDTH = $bits(sdram_pkg::wentry_t),
  parameter int DEPTH = `WBUF_DEPTH
)
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // buffer ports
  wbuf_if.fifo_side bus
);
  import sdram_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } ptr_t;

  ptr_t             s_q;
  ptr_t             s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign empty = (s_q.wr_ptr == s_q.rd_ptr);
  assign full  = (s_q.wr_ptr[AW-1:0] == s_q.rd_ptr[AW-1:0]) &&
                 (s_q.wr_ptr[AW] != s_q.rd_ptr[AW]);
  assign push  = bus.push_valid && !full;
  assign pop   = bus.pop_ready && !empty;

  assign bus.push_ready = !full;
  assign bus.pop_valid  = !empty;
  assign bus.pop_data   = wentry_t'(mem[s_q.rd_ptr[AW-1:0]]);

  always_comb
  begin
    s_d = s_q;
    if (push)
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    if (pop)
      s_d.rd_ptr = s_q.rd_ptr + 1'b1;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[s_q.wr_ptr[AW-1:0]] <= WIDTH'(bus.push_data);
  end

endmodule // sdram_wbuf

/* File: src/sdram_core.sv */
// Purpose: command-level core of a two-bank 16-bit synchronous dram
// Assumes: controller keeps its own spacing limits; inputs synchronous
// Notes:   storage keeps one 256-column page per bank, row is ignored
//
// Overview of operation
// - read lane floats two cycles after mask rises
// - masked lane stays floated; resumes after same latency
// - upper mask owns bits 15:8, lower 7:0
// - read mask gates outputs only; burst continues
// - write lane dropped same cycle mask high
// - write lane resumes the cycle mask falls
// - write mask gates inputs only; burst continues
// - single-write mode stores one item per write except in full page mode
// - single-write mode keeps cas and mask latency
// - low clock enable suspends at next edge
// - suspended core ignores all but clock enable
// - suspended core holds every internal state
// - clock enable high resumes at next edge
`timescale 1ns/1ps

`include "sdram_map.svh"

module sdram_core
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // command pins
  input  wire logic              i_cke,
  input  wire logic              i_cs_n,
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic              i_we_n,
  input  wire logic [11:0]       i_addr,
  // byte lane masks
  input  wire logic              i_upper_byte_mask,
  input  wire logic              i_lower_byte_mask,
  // data pins, one enable per byte lane
  input  wire logic [15:0]       i_dq,
  output logic [15:0]            o_dq,
  output logic [1:0]             o_dq_oe_n,
  // status
  output logic                   o_suspended,
  output logic [1:0]             o_bank_active,
  output logic                   o_burst_active,
  output logic                   o_write_buffer_ready
);
  import sdram_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic cmd_t decode_cmd(input logic ras_n,
                                      input logic cas_n,
                                      input logic we_n);
    cmd_t c;
    c = CMD_NOP;
    case ({ras_n, cas_n, we_n})
      3'h3:    c = CMD_ACT;
      3'h5:    c = CMD_READ;
      3'h4:    c = CMD_WRITE;
      3'h2:    c = CMD_PRE;
      3'h6:    c = CMD_BST;
      3'h1:    c = CMD_REF;
      3'h0:    c = CMD_MRS;
      default: c = CMD_NOP;
    endcase
    return c;
  endfunction

  // burst length minus one; full page wraps on the 8-bit counter
  function automatic logic [`COL_W-1:0] len_mask(input logic [2:0] code);
    logic [`COL_W-1:0] m;
    m = 8'h00;
    case (code)
      3'h1:          m = 8'h01;
      3'h2:          m = 8'h03;
      3'h3:          m = 8'h07;
      `BL_FULL_CODE: m = 8'hFF;
      default:       m = 8'h00;
    endcase
    return m;
  endfunction

  function automatic logic [`COL_W-1:0] col_of(input logic [`COL_W-1:0] start,
                                               input logic [`COL_W-1:0] cnt,
                                               input logic [`COL_W-1:0] m,
                                               input logic il);
    logic [`COL_W-1:0] sum;
    sum = il ? (start ^ cnt) : `COL_W'(start + cnt);
    return (start & ~m) | (sum & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  // reset mode: burst of one, sequential, cas latency two, burst write
  localparam state_t ST_RESET = '{cke_q:      1'h1,
                                  bl_code:    `RST_BL_CODE,
                                  interleave: `RST_INTERLEAVE,
                                  cl3:        `RST_CL3,
                                  single_wr:  `RST_SINGLE_WR,
                                  oe_n:       2'h3,
                                  default:    '0};

  state_t               s_q;
  state_t               s_d;
  logic [`DQ_W-1:0]     store [`STORE_WORDS];
  logic                 en;
  cmd_t                 cmd;
  logic                 beat;
  logic                 beat_wr;
  logic                 beat_bank;
  logic [`COL_W-1:0]    beat_col;
  logic [`COL_W-1:0]    m_len;
  logic [`COL_W-1:0]    m_wr;
  logic [1:0]           mask_now;
  logic                 rd_fetch;
  logic                 sel_v;
  logic [`DQ_W-1:0]     sel_d;
  logic                 full_page;
  wire  [1:0]           lane_wr;

  wbuf_if wb ();

  // internal clock runs only when clock enable was high at the last edge
  assign en        = s_q.cke_q;
  assign cmd       = (en && !i_cs_n) ? decode_cmd(i_ras_n, i_cas_n, i_we_n)
                                     : CMD_NOP;
  assign mask_now  = {i_upper_byte_mask, i_lower_byte_mask};
  assign m_len     = len_mask(s_q.bl_code);
  assign full_page = (s_q.bl_code == `BL_FULL_CODE);
  // single-write mode forces a one-beat write burst except in full page mode
  assign m_wr      = s_q.single_wr ? 8'h00 : m_len;

  ////////////////////////////////////////////////////////////////////////////
  // command and burst sequencing

  always_comb
  begin
    s_d       = s_q;
    s_d.cke_q = i_cke;
    beat      = 1'b0;
    beat_wr   = s_q.b_wr;
    beat_bank = s_q.b_bank;
    beat_col  = col_of(s_q.b_start, s_q.b_cnt,
                       s_q.b_wr ? m_wr : m_len, s_q.interleave);
    if (en)
    begin
      // an open burst keeps counting whatever the masks do
      if (s_q.b_act)
      begin
        beat      = 1'b1;
        s_d.b_cnt = s_q.b_cnt + 1'b1;
        // the last beat still moves data; the burst closes behind it
        if (!full_page &&
            (s_q.b_cnt == (s_q.b_wr ? m_wr : m_len)))
          s_d.b_act = 1'b0;
        if (!full_page && s_q.b_ap &&
            (s_q.b_cnt == (s_q.b_wr ? m_wr : m_len)))
          s_d.bank_act[s_q.b_bank] = 1'b0;
      end
      case (cmd)
        CMD_READ, CMD_WRITE:
        begin
          beat          = 1'b1;
          beat_wr       = (cmd == CMD_WRITE);
          beat_bank     = i_addr[`BANK_BIT];
          beat_col      = i_addr[`COL_W-1:0];
          s_d.b_wr      = beat_wr;
          s_d.b_bank    = beat_bank;
          s_d.b_ap      = i_addr[`AP_BIT] && !full_page;
          s_d.b_start   = i_addr[`COL_W-1:0];
          s_d.b_cnt     = 8'h01;
          s_d.b_act     = full_page ||
                          ((beat_wr ? m_wr : m_len) != 8'h00);
          if (!s_d.b_act && s_d.b_ap)
            s_d.bank_act[beat_bank] = 1'b0;
        end
        CMD_BST:
        begin
          beat      = 1'b0;
          s_d.b_act = 1'b0;
        end
        CMD_PRE:
        begin
          if (s_q.b_act &&
              (i_addr[`AP_BIT] || (i_addr[`BANK_BIT] == s_q.b_bank)))
          begin
            beat      = 1'b0;
            s_d.b_act = 1'b0;
          end
          if (i_addr[`AP_BIT])
            s_d.bank_act = 2'h0;
          else
            s_d.bank_act[i_addr[`BANK_BIT]] = 1'b0;
        end
        CMD_ACT:
          s_d.bank_act[i_addr[`BANK_BIT]] = 1'b1;
        CMD_MRS:
        begin
          s_d.bl_code    = i_addr[`MR_BL_MSB:`MR_BL_LSB];
          s_d.interleave = i_addr[`MR_BT_BIT];
          s_d.cl3        = (i_addr[`MR_CL_MSB:`MR_CL_LSB] == `MR_CL3_CODE);
          s_d.single_wr  = i_addr[`MR_WB_BIT];
        end
        default:
        begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // read pipeline: latency is the same in either write mode
    if (en)
    begin
      // the page is looked up every enabled cycle; pv marks live beats
      // and keeps this process free of a loop through rd_fetch
      s_d.pv[0]  = beat && !beat_wr;
      s_d.pd[0]  = store[{beat_bank, beat_col}];
      s_d.pv[1]  = s_q.pv[0];
      s_d.pd[1]  = s_q.pd[0];
      s_d.mask_q = mask_now;
      if (sel_v)
        s_d.dq = sel_d;
      // mask seen at edge t reaches the pins after edge t+1
      for (int i = 0; i < 2; i++)
        s_d.oe_n[i] = !(sel_v && !s_q.mask_q[i]);
    end
  end

  // cas latency only picks the pipe stage; mask latency stays fixed
  assign rd_fetch = en && beat && !beat_wr;
  assign sel_v    = s_q.cl3 ? s_q.pv[1] : s_q.pv[0];
  assign sel_d    = s_q.cl3 ? s_q.pd[1] : s_q.pd[0];

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      s_q <= ST_RESET;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path: lanes gated by the mask of the same cycle

  assign wb.push_data         = '{bank:    beat_bank,
                                  col:     beat_col,
                                  lane_we: ~mask_now,
                                  data:    i_dq};
  // a fully masked beat still advances the burst but stores nothing
  assign wb.push_valid        = en && beat && beat_wr &&
                                (mask_now != 2'h3);
  // storage is single ported; read fetch wins and the buffer waits
  assign wb.pop_ready         = en && !rd_fetch;

  sdram_wbuf #(
    .WIDTH ($bits(wentry_t)),
    .DEPTH (`WBUF_DEPTH)
  ) u_wbuf (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .bus     (wb.fifo_side)
  );

  // one write enable per lane; a single process owns the array, and a
  // read of a word still queued here returns the older contents
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_lane
      assign lane_wr[g] = wb.pop_valid && wb.pop_ready &&
                          wb.pop_data.lane_we[g];
    end
  endgenerate

  always_ff @(posedge i_clock)
  begin
    for (int i = 0; i < 2; i++)
      if (lane_wr[i])
        store[{wb.pop_data.bank, wb.pop_data.col}][i*8 +: 8] <=
          wb.pop_data.data[i*8 +: 8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_dq                 = s_q.dq;
  assign o_dq_oe_n            = s_q.oe_n;
  assign o_suspended          = !s_q.cke_q;
  assign o_bank_active        = s_q.bank_act;
  assign o_burst_active       = s_q.b_act;
  assign o_write_buffer_ready = wb.push_ready;

endmodule // sdram_core

/* File: bench/sdram_core_properties.sv */
// Purpose: pin-level timing checks for the sdram core
// Assumes: bound to every sdram_core instance
// Notes:   an edge is frozen when clock enable was low one edge before
`timescale 1ns/1ps

module sdram_core_properties
(
  // watched pins
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_cke,
  input wire logic        i_cs_n,
  input wire logic        i_upper_byte_mask,
  input wire logic        i_lower_byte_mask,
  input wire logic [15:0] o_dq,
  input wire logic [1:0]  o_dq_oe_n,
  input wire logic        o_suspended,
  input wire logic [1:0]  o_bank_active,
  input wire logic        o_burst_active
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  AST_UPPER_FLOAT: assert property (
    i_upper_byte_mask && i_cke && $past(i_cke) |=> ##1 o_dq_oe_n[1])
    else $error("upper lane driven two cycles after its mask");
  AST_LOWER_FLOAT: assert property (
    i_lower_byte_mask && i_cke && $past(i_cke) |=> ##1 o_dq_oe_n[0])
    else $error("lower lane driven two cycles after its mask");
  AST_MASK_HOLD: assert property (
    (i_lower_byte_mask && i_cke && $past(i_cke)) [*2] |=> o_dq_oe_n[0] [*2])
    else $error("lower lane not held floated");
  AST_MASK_RESUME: assert property (
    !o_dq_oe_n[1] && $past(i_cke, 2) && $past(i_cke, 3)
    |-> !$past(i_upper_byte_mask, 2))
    else $error("upper lane driven too early after mask");
  AST_SUSPEND_ENTER: assert property (!i_cke |=> o_suspended)
    else $error("suspend not entered");
  AST_SUSPEND_EXIT: assert property (
    $rose(i_cke) && o_suspended |=> !o_suspended)
    else $error("suspend not left");
  AST_SUSPEND_HOLD: assert property (
    o_suspended |=> $stable(o_dq) && $stable(o_dq_oe_n)
    && $stable(o_burst_active))
    else $error("state moved while suspended");
  AST_SUSPEND_IGNORE: assert property (
    !$past(i_cke) && !i_cs_n |=> $stable(o_bank_active) &&
    $stable(o_burst_active))
    else $error("command taken while suspended");
endmodule // sdram_core_properties

bind sdram_core sdram_core_properties chk
(
  .i_clock, .i_rst_n, .i_cke, .i_cs_n, .i_upper_byte_mask,
  .i_lower_byte_mask, .o_dq, .o_dq_oe_n, .o_suspended,
  .o_bank_active, .o_burst_active
);

/* File: bench/ctrl_model.sv */
// Purpose: memory controller model on the command side of the core
// Assumes: the bench calls cyc once per clock
// Notes:   spacing limits are met by padding with idle cycles
`timescale 1ns/1ps

module ctrl_model
#(
  parameter int GAP = 3
)
(
  // clock
  input  wire logic   i_clock,
  // command side
  output logic        o_cke,
  output logic        o_cs_n,
  output logic [2:0]  o_cmd,
  output logic [11:0] o_addr,
  output logic [1:0]  o_mask,
  output logic [15:0] o_dq
);
  initial
  begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    o_cmd = 3'h7;
    o_addr = 12'h000;
    o_mask = 2'h0;
    o_dq = 16'h0000;
  end

  // released data lines toggle so a stale value never passes
  task automatic cyc(input logic [2:0] c, input logic [11:0] a,
                     input logic [1:0] m, input logic [15:0] d,
                     input logic w, input logic k);
    @(posedge i_clock);
    o_cmd <= c;
    o_cs_n <= (c == 3'h7);
    o_addr <= a;
    o_mask <= m;
    o_dq <= w ? d : ~o_dq;
    o_cke <= k;
  endtask

  task automatic open_bank(input logic b);
    cyc(3'h3, {b, 11'h000}, 2'h0, 16'h0000, 1'b0, 1'b1);
    repeat (GAP) cyc(3'h7, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b1);
  endtask

  task automatic close_bank(input logic b);
    repeat (GAP) cyc(3'h7, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b1);
    cyc(3'h2, {b, 11'h000}, 2'h0, 16'h0000, 1'b0, 1'b1);
  endtask
endmodule // ctrl_model

/* File: bench/test_sdram_core.sv */
// Purpose: self-checking bench for the sdram core
// Assumes: bank 0 only, burst length four
// Notes:   expectations come from a shadow copy of the page
`timescale 1ns/1ps

module test_sdram_core;
  localparam logic [2:0] RD = 3'h5;
  localparam logic [2:0] WR = 3'h4;
  localparam logic [2:0] NOP = 3'h7;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        cke, cs_n, susp, burst, ready;
  logic [2:0]  cmd;
  logic [11:0] addr;
  logic [1:0]  mask, oe_n, bank;
  logic [15:0] dq_in, dq_out;
  logic [15:0] mem [0:255];
  int          bad_count = 0;
  int          checked = 0;

  always #25 i_clock = ~i_clock;

  ctrl_model ctrl (.i_clock(i_clock), .o_cke(cke), .o_cs_n(cs_n),
    .o_cmd(cmd), .o_addr(addr), .o_mask(mask), .o_dq(dq_in));

  sdram_core uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cke(cke),
    .i_cs_n(cs_n), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
    .i_addr(addr), .i_upper_byte_mask(mask[1]),
    .i_lower_byte_mask(mask[0]), .i_dq(dq_in), .o_dq(dq_out),
    .o_dq_oe_n(oe_n), .o_suspended(susp), .o_bank_active(bank),
    .o_burst_active(burst), .o_write_buffer_ready(ready));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cy(input logic [2:0] c, input logic [11:0] a,
                    input logic [1:0] m, input logic [15:0] d,
                    input logic w, input logic k);
    ctrl.cyc(c, a, m, d, w, k);
    #1;
  endtask

  task automatic wr(input logic [7:0] col, input logic [15:0] base,
                    input logic [7:0] ms, input logic one);
    logic [15:0] d;
    cy(3'h0, {2'h0, one, 9'h022}, 2'h0, 16'h0000, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      d = base + 16'(k * 257);
      cy(k == 0 ? WR : NOP, {4'h0, col}, ms[2*k +: 2], d, 1'b1, 1'b1);
      if (k == 0 || !one)
      begin
        if (!ms[2*k]) mem[col+k][7:0] = d[7:0];
        if (!ms[2*k+1]) mem[col+k][15:8] = d[15:8];
      end
    end
    repeat (6) cy(NOP, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b1);
  endtask

  // upper mask rises one cycle after the read; lower is held at the tail
  task automatic rd(input logic [7:0] col, input int cl, input logic sw);
    int b;
    cy(3'h0, {2'h0, sw, 3'h0, cl == 3 ? 2'h3 : 2'h2, 4'h2}, 2'h0,
       16'h0000, 1'b0, 1'b1);
    cy(RD, {4'h0, col}, 2'h0, 16'h0000, 1'b0, 1'b1);
    for (int j = 1; j <= 6; j++)
    begin
      cy(NOP, 12'h000, j == 1 ? 2'h2 : (j >= 5 ? 2'h1 : 2'h0),
         16'h0000, 1'b0, 1'b1);
      b = j - cl;
      if (b >= 0 && b < 4)
      begin
        chk({14'h0, oe_n}, {14'h0, j == 3, 1'b0});
        if (j == 3)
          chk({8'h00, dq_out[7:0]}, {8'h00, mem[col+b][7:0]});
        else
          chk(dq_out, mem[col+b]);
      end
      else
        chk({14'h0, oe_n}, 16'h0003);
    end
  endtask

  // a write command is offered while frozen and must be dropped
  task automatic susp_read;
    int b;
    cy(RD, 12'h010, 2'h0, 16'h0000, 1'b0, 1'b1);
    cy(NOP, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b1);
    for (int j = 2; j <= 8; j++)
    begin
      cy(j == 4 ? WR : NOP, 12'h000, 2'h0, 16'hFFFF, j == 4, j > 4);
      b = j < 4 ? j - 2 : (j < 7 ? 1 : j - 5);
      chk(dq_out, mem[8'h10+b]);
      chk({15'h0, susp}, {15'h0, j >= 3 && j <= 5});
      chk({15'h0, burst}, {15'h0, j <= 6});
    end
    repeat (4) cy(NOP, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b1);
  endtask

  task automatic end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (2000) @(posedge i_clock);
    bad_count++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    chk(dq_out, 16'h0000);
    chk({10'h0, oe_n, susp, bank, ready}, 16'h0031);
    ctrl.open_bank(1'b0);
    #1;
    chk({14'h0, bank}, 16'h0001);
    wr(8'h10, 16'h1100, 8'h00, 1'b0);
    wr(8'h10, 16'hA050, 8'hE4, 1'b0);
    rd(8'h10, 2, 1'b0);
    rd(8'h10, 3, 1'b0);
    wr(8'h20, 16'h2200, 8'h00, 1'b0);
    wr(8'h20, 16'h5A00, 8'h00, 1'b1);
    rd(8'h20, 2, 1'b1);
    susp_read();
    ctrl.close_bank(1'b0);
    repeat (3) cy(NOP, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b1);
    chk({14'h0, bank}, 16'h0000);
    end_of_test();
  end
endmodule // test_sdram_core
